// ==== logic/mrr_pkg.sv ====
// Constants, types and register map of the main converter sequencer.
`default_nettype none
package mrr_pkg;
   // Clock rate and slot timing.
   localparam int CLK_PERIOD_NS = 100;
   localparam int SLOT_TIME_NS = 8000;
   localparam int PASS_TIME_NS = 192000;
   localparam int SLOT_CYCLES = SLOT_TIME_NS / CLK_PERIOD_NS;
   localparam int PASS_CYCLES = PASS_TIME_NS / CLK_PERIOD_NS;
   localparam logic [6:0] SLOT_END_CNT = 7'(SLOT_CYCLES - 1);
   // Slot schedule.
   localparam int NUM_SLOTS = 24;
   localparam int NUM_RES = 27;
   localparam logic [4:0] SLOT_DIE = 5'h00;
   localparam logic [4:0] SLOT_CELL1 = 5'h02;
   localparam logic [4:0] SLOT_CELL16 = 5'h11;
   localparam logic [4:0] SLOT_BUS = 5'h12;
   localparam logic [4:0] SLOT_GPIO = 5'h13;
   localparam logic [4:0] SLOT_LAST = 5'h17;
   localparam logic [15:0] RESULT_DEFAULT = 16'h8000;
   // Register byte offsets.
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STAT_OFS = 12'h004;
   localparam logic [11:0] RES_BASE = 12'h100;
   localparam logic [11:0] RES_END = 12'h1d8;
   localparam logic [11:0] CTRL_RESET = 12'h000;
   // Control register layout, bit 0 at the right.
   typedef struct packed {
      logic [3:0] cell_count;
      logic align_en;
      logic [2:0] lpf_sel;
      logic lpf_en;
      logic bias_en;
      logic aux_en;
      logic main_en;
   } mrr_ctrl_s;
   // Bus request held for the data phase.
   typedef struct packed {
      logic [11:0] addr;
      logic write;
   } mrr_req_s;
   // Sequencer states, Gray coded.
   typedef enum logic [1:0] {
      MRR_IDLE = 2'b00,
      MRR_RUN = 2'b01,
      MRR_WAIT = 2'b11
   } mrr_state_e;
endpackage : mrr_pkg
`default_nettype wire

// ==== logic/mrr_sequencer.sv ====
// Round robin sequencer and result registers of the main converter.
//
// Overview of operation
// - Twenty-four slots converted in fixed round robin.
// - Each slot 8 us, full pass 192 us.
// - Slots: die, bias, cells, bus, gpio, spares.
// - Results are 16-bit signed, high/low byte pair.
// - Enabling the converter loads all results 0x8000.
// - Each result updates when its slot ends.
// - High-byte read freezes low byte until read.
// - Die temperature stored signed, zero is 0 C.
// - Main and auxiliary converters enable separately.
// - Bias reference off at reset, own enable bit.
// - Every cell channel has its own lowpass.
// - Optional aligned start, cells within 128 us.
// - GPIO slot advances one input per pass.
// - Inactive cell slots skipped, keep their time.
// - Cell count sets highest active cell.
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mrr_sequencer
   import mrr_pkg::*;
(
   // Clock, reset and clock enable.
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   // AHB-Lite slave.
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // Converter side.
   input wire logic [15:0] conv_data_in,
   input wire logic sync_start_in,
   output logic [4:0] slot_sel_out,
   output logic [2:0] gpio_sel_out,
   output logic main_enable_out,
   output logic aux_enable_out,
   output logic bias_reference_enable_out
);

   mrr_ctrl_s ctrl_q;
   mrr_req_s dreq_q;
   mrr_state_e state_q;
   mrr_state_e state_d;
   logic [4:0] slot_q;
   logic [6:0] tmr_q;
   logic [2:0] gpio_q;
   logic [15:0] res_q [NUM_RES];
   logic [7:0] lo_q [NUM_RES];
   logic [NUM_RES-1:0] frz_q;
   logic [NUM_RES-1:0] prim_q;
   logic en_prev_q;
   logic [1:0] sync_q;
   logic sync_prev_q;
   logic [31:0] hrdata_q;
   logic hready_q;

   // Result index of a slot; spare slots are never written.
   function automatic logic [4:0] res_index(input logic [4:0] s,
                                            input logic [2:0] g);
      res_index = (s == SLOT_GPIO) ? SLOT_GPIO + {2'b00, g} : s;
   endfunction : res_index

   // A cell numbered n+1 is active when n is not above the count.
   function automatic logic cell_on(input logic [4:0] s,
                                    input logic [3:0] cnt);
      logic [4:0] n;
      n = s - SLOT_CELL1;
      cell_on = (n <= {1'b0, cnt});
   endfunction : cell_on

   // Single-pole lowpass: step by the difference shifted by sel+1.
   function automatic logic [15:0] post_conversion_lowpass(input logic [15:0] prev,
                                       input logic [15:0] x,
                                       input logic [2:0] sel);
      logic signed [16:0] dif;
      dif = $signed({x[15], x}) - $signed({prev[15], prev});
      dif = dif >>> ({1'b0, sel} + 4'h1);
      post_conversion_lowpass = prev + dif[15:0];
   endfunction : post_conversion_lowpass

   // Bus address decode in the address phase.
   wire addr_take = hsel_in & htrans_in[1] & hready_in;
   wire [11:0] a_w = haddr_in[11:0];
   wire in_res = (a_w >= RES_BASE) && (a_w < RES_END);
   wire [11:0] a_off = a_w - RES_BASE;
   wire [4:0] ridx = in_res ? a_off[7:3] : 5'h00;
   wire rd_hi = addr_take & ~hwrite_in & in_res & ~a_w[2];
   wire rd_lo = addr_take & ~hwrite_in & in_res & a_w[2];
   wire ctrl_wr = dreq_q.write && (dreq_q.addr == CTRL_OFS);

   // Read data chosen in the address phase, zero where unmapped.
   wire [31:0] stat_w = {23'h000000, state_q == MRR_RUN, gpio_q,
                         slot_q};
   wire [31:0] rdata_w =
      (a_w == CTRL_OFS) ? {20'h00000, ctrl_q} :
      (a_w == STAT_OFS) ? stat_w :
      rd_hi ? {24'h000000, res_q[ridx][15:8]} :
      rd_lo ? {24'h000000, lo_q[ridx]} : 32'h00000000;

   // Sequencer decode.
   wire start = ctrl_q.main_en & ~en_prev_q;
   wire slot_end = (state_q == MRR_RUN) && (tmr_q == SLOT_END_CNT);
   wire pass_end = slot_end && (slot_q == SLOT_LAST);
   wire sync_rise = sync_q[1] & ~sync_prev_q;
   wire is_cell = (slot_q >= SLOT_CELL1) && (slot_q <= SLOT_CELL16);
   wire [4:0] widx = res_index(slot_q, gpio_q);
   wire cell_ok = cell_on(slot_q, ctrl_q.cell_count);
   wire conv_ok = (slot_q <= SLOT_GPIO) && (!is_cell || cell_ok);
   wire filt = ctrl_q.lpf_en && is_cell && prim_q[widx];
   wire [15:0] new_w = filt ?
      post_conversion_lowpass(res_q[widx], conv_data_in, ctrl_q.lpf_sel) : conv_data_in;

   // Next state of the pass sequencer.
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         MRR_IDLE: begin
            if (start) begin
               state_d = MRR_RUN;
            end
         end
         MRR_RUN: begin
            if (pass_end && ctrl_q.align_en) begin
               state_d = MRR_WAIT;
            end
         end
         MRR_WAIT: begin
            if (sync_rise) begin
               state_d = MRR_RUN;
            end
         end
         default: begin
            state_d = MRR_IDLE;
         end
      endcase
      if (!ctrl_q.main_en) begin
         state_d = MRR_IDLE;
      end
   end

   // Bus slave: zero wait states, always OKAY.
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         dreq_q <= '0;
         hrdata_q <= 32'h00000000;
         hready_q <= 1'b0;
         ctrl_q <= CTRL_RESET;
      end else if (ce_in) begin
         hready_q <= 1'b1;
         dreq_q.write <= addr_take & hwrite_in;
         dreq_q.addr <= a_w;
         hrdata_q <= rdata_w;
         if (ctrl_wr) begin
            ctrl_q <= hwdata_in[11:0];
         end
      end
   end

   // Slot timer, slot counter and rotating GPIO select.
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         state_q <= MRR_IDLE;
         slot_q <= SLOT_DIE;
         tmr_q <= 7'h00;
         gpio_q <= 3'h0;
         en_prev_q <= 1'b0;
         sync_q <= 2'b00;
         sync_prev_q <= 1'b0;
      end else if (ce_in) begin
         state_q <= state_d;
         en_prev_q <= ctrl_q.main_en;
         sync_q <= {sync_q[0], sync_start_in};
         sync_prev_q <= sync_q[1];
         if (state_d != MRR_RUN || state_q != MRR_RUN) begin
            tmr_q <= 7'h00;
            slot_q <= SLOT_DIE;
         end else if (slot_end) begin
            tmr_q <= 7'h00;
            slot_q <= pass_end ? SLOT_DIE : slot_q + 5'h01;
         end else begin
            tmr_q <= tmr_q + 7'h01;
         end
         if (start) begin
            gpio_q <= 3'h0;
         end else if (pass_end) begin
            gpio_q <= gpio_q + 3'h1;
         end
      end
   end

   // Result pairs, low-byte freeze and lowpass priming.
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         frz_q <= '0;
         prim_q <= '0;
         for (int r = 0; r < NUM_RES; r++) begin
            res_q[r] <= RESULT_DEFAULT;
            lo_q[r] <= RESULT_DEFAULT[7:0];
         end
      end else if (ce_in) begin
         for (int r = 0; r < NUM_RES; r++) begin
            if (start) begin
               res_q[r] <= RESULT_DEFAULT;
               lo_q[r] <= RESULT_DEFAULT[7:0];
               frz_q[r] <= 1'b0;
               prim_q[r] <= 1'b0;
            end else begin
               if (slot_end && conv_ok && widx == 5'(r)) begin
                  res_q[r] <= new_w;
                  prim_q[r] <= ctrl_q.lpf_en;
               end else if (!ctrl_q.lpf_en) begin
                  prim_q[r] <= 1'b0;
               end
               if (rd_hi && ridx == 5'(r)) begin
                  frz_q[r] <= 1'b1;
                  lo_q[r] <= res_q[r][7:0];
               end else begin
                  if (rd_lo && ridx == 5'(r)) begin
                     frz_q[r] <= 1'b0;
                  end
                  if (!frz_q[r]) begin
                     lo_q[r] <= res_q[r][7:0];
                  end
               end
            end
         end
      end
   end

   // Outputs straight from flip-flops, except hresp_out tied low to OKAY.
   assign hrdata_out = hrdata_q;
   assign hreadyout_out = hready_q;
   assign hresp_out = 1'b0;
   assign slot_sel_out = slot_q;
   assign gpio_sel_out = gpio_q;
   assign main_enable_out = ctrl_q.main_en;
   assign aux_enable_out = ctrl_q.aux_en;
   assign bias_reference_enable_out = ctrl_q.bias_en;

   // Cycle count since the pass began, read only by checks.
   logic [10:0] pass_cnt_q;
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         pass_cnt_q <= 11'h000;
      end else if (ce_in) begin
         if (state_q != MRR_RUN || pass_end) begin
            pass_cnt_q <= 11'h000;
         end else begin
            pass_cnt_q <= pass_cnt_q + 11'h001;
         end
      end
   end

   sequence s_pass_done;
      ce_in && pass_end && !ctrl_q.align_en && ctrl_q.main_en;
   endsequence

   sequence s_restart;
      slot_q == SLOT_DIE && tmr_q == 7'h00 && state_q == MRR_RUN;
   endsequence

   pass_len_a: assert property (@(posedge clk_in)
      disable iff (!resetn_in)
      ce_in && pass_end |-> pass_cnt_q == 11'(PASS_CYCLES - 1))
      else $error("Pass length wrong.");

   slot_wrap_a: assert property (@(posedge clk_in)
      disable iff (!resetn_in)
      s_pass_done |=> s_restart)
      else $error("Next pass did not start at once.");

   slot_range_a: assert property (@(posedge clk_in)
      disable iff (!resetn_in)
      slot_q <= SLOT_LAST)
      else $error("Slot out of range.");

   default_load_a: assert property (@(posedge clk_in)
      disable iff (!resetn_in)
      ce_in && start |=> res_q[0] == RESULT_DEFAULT &&
      res_q[NUM_RES-1] == RESULT_DEFAULT && lo_q[5] == 8'h00)
      else $error("Results not defaulted on enable.");

   update_a: assert property (@(posedge clk_in)
      disable iff (!resetn_in)
      ce_in && slot_end && conv_ok && !start |=>
      res_q[$past(widx)] == $past(new_w))
      else $error("Result not updated at slot end.");

   freeze_a: assert property (@(posedge clk_in)
      disable iff (!resetn_in)
      ce_in && frz_q[widx] && slot_end && conv_ok && !start &&
      !(rd_lo && ridx == widx) && !(rd_hi && ridx == widx) |=>
      lo_q[$past(widx)] == $past(lo_q[widx]))
      else $error("Frozen low byte changed.");

   skip_a: assert property (@(posedge clk_in)
      disable iff (!resetn_in)
      ce_in && slot_end && is_cell && !cell_ok && !start |=>
      res_q[$past(widx)] == $past(res_q[widx]) && tmr_q == 7'h00)
      else $error("Inactive cell was converted.");

   gpio_step_a: assert property (@(posedge clk_in)
      disable iff (!resetn_in)
      ce_in && pass_end && !start |=> gpio_q == $past(gpio_q) + 3'h1)
      else $error("GPIO slot did not advance.");

   bias_off_a: assert property (@(posedge clk_in)
      disable iff (!resetn_in)
      !$past(resetn_in) |-> !bias_reference_enable_out)
      else $error("Bias reference on after reset.");

   ctrl_write_a: assert property (@(posedge clk_in)
      disable iff (!resetn_in)
      ce_in && ctrl_wr |=> aux_enable_out == $past(hwdata_in[1]) &&
      main_enable_out == $past(hwdata_in[0]))
      else $error("Enable bits not written.");

endmodule : mrr_sequencer
`default_nettype wire

// ==== sim/mrr_host_model.sv ====
// Host model: AHB-Lite master and its control register habits.
`timescale 1ns/1ps
`default_nettype none
module mrr_host_model
   import mrr_pkg::*;
(
   // Clock and slave answer.
   input wire logic clk_in,
   input wire logic hready_in,
   input wire logic [31:0] hrdata_in,
   // Master request.
   output logic hsel_out,
   output logic [31:0] haddr_out,
   output logic [1:0] htrans_out,
   output logic hwrite_out,
   output logic [2:0] hsize_out,
   output logic [31:0] hwdata_out
);
   logic bias_on = 1'b0;
   // Bus idle at time zero.
   initial begin
      hsel_out = 1'b0;
      haddr_out = 32'h0;
      htrans_out = 2'b00;
      hwrite_out = 1'b0;
      hsize_out = 3'h2;
      hwdata_out = 32'h0;
   end
   // Waits for hready at a rising edge, with a bound.
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
         if (n > 50) begin
            testbench.failures++;
            testbench.print_verdict();
         end
      end while (hready_in !== 1'b1);
   endtask : wait_ready
   // One single word transfer, address phase then data phase.
   task automatic xfer(input logic wr, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_in);
      hsel_out <= 1'b1;
      haddr_out <= {20'h0, a};
      htrans_out <= 2'b10;
      hwrite_out <= wr;
      wait_ready();
      hsel_out <= 1'b0;
      htrans_out <= 2'b00;
      hwdata_out <= wd;
      wait_ready();
      rd = hrdata_in;
      // The bias reference must settle before any further command.
      if (wr && a == CTRL_OFS) begin
         if (wd[2] && !bias_on) begin
            repeat (13500) @(posedge clk_in);
         end
         bias_on = wd[2];
      end
   endtask : xfer
endmodule : mrr_host_model
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking testbench of the main converter sequencer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import mrr_pkg::*;
   typedef struct {logic [11:0] a; logic [31:0] e;} mrr_row_s;
   // Clock, reset, converter stimulus and design wires.
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic sync = 1'b0;
   logic [15:0] conv = 16'h0;
   logic [7:0] tag_q = 8'h20;
   logic hsel, hwrite, hrdy, hresp, m_en, a_en, b_en;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize, gsel;
   logic [4:0] slot;
   int failures = 0;
   int checks_done = 0;
   // Clock of 100 ns.
   initial begin
      forever #50 clk_in = ~clk_in;
   end
   // Converter answer carries its slot and the current tag.
   always @(posedge clk_in) conv <= {3'h5, slot, tag_q};
   // Design and host.
   mrr_sequencer mrr_sequencer_inst (.clk_in(clk_in),
      .resetn_in(resetn_in), .ce_in(1'b1), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hrdy),
      .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
      .conv_data_in(conv), .sync_start_in(sync), .slot_sel_out(slot),
      .gpio_sel_out(gsel), .main_enable_out(m_en),
      .aux_enable_out(a_en), .bias_reference_enable_out(b_en));
   mrr_host_model mrr_host_model_inst (.clk_in(clk_in),
      .hready_in(hrdy), .hrdata_in(hrdata), .hsel_out(hsel),
      .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite),
      .hsize_out(hsize), .hwdata_out(hwdata));
   // Comparison, counted.
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : check
   // Closing report.
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict
   // Register accesses through the host.
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      mrr_host_model_inst.xfer(1'b0, a, 32'h0, d);
   endtask : rd
   task automatic wr(input logic [11:0] a, input logic [31:0] w);
      logic [31:0] d;
      mrr_host_model_inst.xfer(1'b1, a, w, d);
   endtask : wr
   task automatic res(input int r, output logic [31:0] v);
      logic [31:0] h, l;
      rd(12'h100 + 12'(8 * r), h);
      rd(12'h104 + 12'(8 * r), l);
      v = {h[23:0], 8'h0} | l;
   endtask : res
   // Counts settled cycles until the slot shows s, bounded.
   task automatic wait_slot(input logic [4:0] s, output int n);
      n = 0;
      while (slot !== s) begin
         @(posedge clk_in);
         #1;
         n++;
         if (n > 4000) begin
            failures++;
            print_verdict();
         end
      end
   endtask : wait_slot
   // Expected results two passes after enable, tags 20 then 60.
   function automatic logic [31:0] exp_res(input int r);
      if (r == 16 || r == 17 || r > 20) return 32'h8000;
      if (r >= 2 && r <= 15) return {19'h5, 5'(r), 8'h40};
      if (r == 19) return 32'hb320;
      if (r == 20) return 32'hb360;
      return {19'h5, 5'(r), 8'h60};
   endfunction : exp_res
   // Main sequence.
   initial begin
      mrr_row_s rows [7];
      logic [31:0] d;
      int n, m;
      time t0;
      rows = '{'{12'h000, 32'h0}, '{12'h004, 32'h0}, '{12'h104, 32'h0},
         '{12'h100, 32'h80}, '{12'h1d0, 32'h80}, '{12'h1d8, 32'h0},
         '{12'h008, 32'h0}};
      repeat (2) @(posedge clk_in);
      resetn_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      foreach (rows[i]) begin
         rd(rows[i].a, d);
         check(d, rows[i].e);
      end
      wr(12'h100, 32'hff);
      rd(12'h100, d);
      check(d, 32'h80);
      check({29'h0, m_en, a_en, b_en}, 32'h0);
      $display("Test reset and decode done");
      wr(CTRL_OFS, 32'h6);
      #1;
      check({24'h0, slot, m_en, a_en, b_en}, 32'h3);
      wr(CTRL_OFS, 32'hd0f);
      wait_slot(5'h01, n);
      wait_slot(5'h02, n);
      check(32'(n), 32'd80);
      check({28'h0, hresp, m_en, a_en, b_en}, 32'h7);
      wait_slot(5'h03, n);
      t0 = $time;
      res(2, d);
      check(d, 32'ha220);
      res(18, d);
      check(d, 32'h8000);
      wait_slot(5'h00, n);
      tag_q <= 8'h60;
      check({29'h0, gsel}, 32'h1);
      wait_slot(5'h03, m);
      check(32'(($time - t0) / 100), 32'd1920);
      wait_slot(5'h00, n);
      for (int r = 0; r < NUM_RES; r++) begin
         res(r, d);
         check(d, exp_res(r));
      end
      $display("Test passes and results done");
      rd(12'h100, d);
      check(d, 32'ha0);
      tag_q <= 8'h90;
      wait_slot(5'h00, n);
      wait_slot(5'h01, n);
      rd(12'h104, d);
      check(d, 32'h60);
      rd(12'h104, d);
      check(d, 32'h90);
      wr(CTRL_OFS, 32'hd0e);
      wr(CTRL_OFS, 32'hd0f);
      res(0, d);
      check(d, 32'h8000);
      $display("Test freeze and restart done");
      wr(CTRL_OFS, 32'hd8f);
      wait_slot(5'h17, n);
      repeat (100) @(posedge clk_in);
      sync <= 1'b1;
      repeat (5) @(posedge clk_in);
      sync <= 1'b0;
      wait_slot(5'h01, n);
      check(32'(n > 75 && n < 86), 32'h1);
      $display("Test aligned start done");
      @(posedge clk_in);
      resetn_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1;
      check({23'h0, hrdy, m_en, a_en, b_en, slot}, 32'h0);
      @(posedge clk_in);
      resetn_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rd(CTRL_OFS, d);
      check(d, 32'h0);
      res(2, d);
      check(d, 32'h8000);
      $display("Test reset in mid-run done");
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
